// ### core/pwm_fault_consts.vh
// Constants for the modulator fault and output control block
`ifndef PWM_FAULT_CONSTS_VH
`define PWM_FAULT_CONSTS_VH

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define CH_COUNT        6
`define PAIR_COUNT      3
`define SRC_COUNT       3
`define ADDR_W          8

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_CONTROL     8'h00
`define OFS_FAULT_CTL   8'h04
`define OFS_FAULT_STAT  8'h08
`define OFS_IRQ_MASK    8'h0c
`define OFS_READBACK    8'h10
`define OFS_OFF_LEVEL   8'h14

// ---------------------------------------------------------------
// Fields
// ---------------------------------------------------------------
`define CTL_ENABLE_BIT  0
`define CTL_PAIR_LSB    1
`define FCTL_SRCEN_LSB  0
`define FCTL_AUTO_LSB   3
`define FSTAT_FLAG_LSB  0
`define FSTAT_LIVE_LSB  3
`define FSTAT_OFF_BIT   6

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_CONTROL     4'h0
`define RST_SRC_EN      3'h7
`define RST_AUTO        3'h0
`define RST_FLAGS       3'h0
`define RST_MASK        3'h0
`define RST_OFF_LEVEL   6'h00
`define RST_PINS        6'h00

// ---------------------------------------------------------------
// Bus answers
// ---------------------------------------------------------------
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define DATA_ZERO       32'h00000000

`endif

// ### core/axil_slave_port.v
// AXI4-Lite slave handshake that hands single-word accesses to the core
`timescale 1ns/1ps
`default_nettype none
`include "pwm_fault_consts.vh"

module axil_slave_port (
   // Clock and reset
   input  wire                 core_clk,
   input  wire                 sys_rst,
   // Write address and data
   input  wire                 awvalid,
   output reg                  awready,
   input  wire [`ADDR_W-1:0]   awaddr,
   input  wire                 wvalid,
   output reg                  wready,
   input  wire [31:0]          wdata,
   input  wire [3:0]           wstrb,
   // Write response
   output reg                  bvalid,
   input  wire                 bready,
   output reg  [1:0]           bresp,
   // Read address and data
   input  wire                 arvalid,
   output reg                  arready,
   input  wire [`ADDR_W-1:0]   araddr,
   output reg                  rvalid,
   input  wire                 rready,
   output reg  [31:0]          rdata,
   output reg  [1:0]           rresp,
   // Core side
   output wire                 wrEn,
   output reg  [`ADDR_W-1:0]   wrAddr,
   output reg  [31:0]          wrData,
   output reg  [3:0]           wrStrb,
   input  wire                 wrOk,
   output wire [`ADDR_W-1:0]   rdAddr,
   input  wire [31:0]          rdData,
   input  wire                 rdOk
);

   // Both halves held, response not yet out
   assign wrEn   = ~awready & ~wready & ~bvalid;
   assign rdAddr = araddr;

   always @(posedge core_clk) begin
      if (sys_rst) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         bvalid  <= 1'b0;
         bresp   <= `RESP_OKAY;
         wrAddr  <= {`ADDR_W{1'b0}};
         wrData  <= `DATA_ZERO;
         wrStrb  <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            wrAddr  <= awaddr;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            wrData <= wdata;
            wrStrb <= wstrb;
         end
         if (wrEn) begin
            bvalid <= 1'b1;
            bresp  <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // Reads have no side effects, so data is captured at address time
   always @(posedge core_clk) begin
      if (sys_rst) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= `DATA_ZERO;
         rresp   <= `RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rdOk ? rdData : `DATA_ZERO;
            rresp   <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ### core/pwm_fault_output_control.v
// Fault override and pin control for a six-output modulator
// ---------------------------------------------------------------
// What this block does
// R1 - A fault forces outputs off; only software or fault release returns them
// R2 - Fault control register selects automatic or software restart
// R3 - Per-source modes give cycle-by-cycle limiting or latched hard shutdown
// R4 - Automatic restart re-engages at period start if all faults are gone
// R5 - Software restart needs all faults gone and flags cleared by software
// R6 - Fault raises interrupt; status register names the causing source
// R7 - Fault to pin path is combinational, works with clock stopped
// R8 - In halt mode the modulator keeps running while enabled
// R9 - Software should clear the enable bit before halting to save power
// R10 - In stop mode outputs hold their last level
// R11 - Software should disable outputs before entering stop mode
// R12 - A fault during stop still forces outputs to their off level
// R13 - Readback register returns sampled levels of the output pins
// R14 - Pair with option bit clear leaves both pins undriven, usable as inputs
// R15 - Each source sets its own sticky flag until software clears it
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "pwm_fault_consts.vh"

module pwm_fault_output_control (
   // Clock and reset
   input  wire                   core_clk,
   input  wire                   sys_rst,
   // Register bus
   input  wire                   awvalid,
   output wire                   awready,
   input  wire [`ADDR_W-1:0]     awaddr,
   input  wire                   wvalid,
   output wire                   wready,
   input  wire [31:0]            wdata,
   input  wire [3:0]             wstrb,
   output wire                   bvalid,
   input  wire                   bready,
   output wire [1:0]             bresp,
   input  wire                   arvalid,
   output wire                   arready,
   input  wire [`ADDR_W-1:0]     araddr,
   output wire                   rvalid,
   input  wire                   rready,
   output wire [31:0]            rdata,
   output wire [1:0]             rresp,
   // Modulator core
   input  wire [`CH_COUNT-1:0]   modRaw,
   input  wire                   periodStart,
   // Power modes
   input  wire                   haltMode,
   input  wire                   stopMode,
   // Fault sources
   input  wire                   faultPin,
   input  wire                   faultCmp0,
   input  wire                   faultCmp1,
   // Output pins
   input  wire [`CH_COUNT-1:0]   pwmPinIn,
   output wire [`CH_COUNT-1:0]   pwmPinOut,
   output reg  [`CH_COUNT-1:0]   pwmPinOe,
   // Interrupt
   output reg                    faultIrq
);

   // ---------------------------------------------------------------
   // Registers and wires
   // ---------------------------------------------------------------
   reg                    modEnable_reg;
   reg  [`PAIR_COUNT-1:0] pairOption_reg;
   reg  [`SRC_COUNT-1:0]  srcEnable_reg;
   reg  [`SRC_COUNT-1:0]  autoRestart_reg;
   reg  [`SRC_COUNT-1:0]  faultFlag_reg;
   reg  [`SRC_COUNT-1:0]  faultFlag_next;
   reg  [`SRC_COUNT-1:0]  irqMask_reg;
   reg  [`CH_COUNT-1:0]   offLevel_reg;
   reg  [`CH_COUNT-1:0]   pinDrive_reg;
   reg  [`CH_COUNT-1:0]   pinDrive_next;
   reg  [`CH_COUNT-1:0]   readback_reg;
   reg  [`SRC_COUNT-1:0]  shutdown_reg;
   reg  [`SRC_COUNT-1:0]  shutdown_next;
   reg  [31:0]            rdWord;
   reg                    rdHit;
   reg                    wrHit;

   wire                   wrEn;
   wire [`ADDR_W-1:0]     wrAddr;
   wire [31:0]            wrData;
   wire [3:0]             wrStrb;
   wire [`ADDR_W-1:0]     rdAddr;
   wire [`SRC_COUNT-1:0]  faultRaw;
   wire [`SRC_COUNT-1:0]  faultLive;
   wire                   anyLive;
   wire                   forceOff;
   wire                   lowByteWr;
   wire [`SRC_COUNT-1:0]  flagClear;

   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   axil_slave_port busPort (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .awvalid  (awvalid),
      .awready  (awready),
      .awaddr   (awaddr),
      .wvalid   (wvalid),
      .wready   (wready),
      .wdata    (wdata),
      .wstrb    (wstrb),
      .bvalid   (bvalid),
      .bready   (bready),
      .bresp    (bresp),
      .arvalid  (arvalid),
      .arready  (arready),
      .araddr   (araddr),
      .rvalid   (rvalid),
      .rready   (rready),
      .rdata    (rdata),
      .rresp    (rresp),
      .wrEn     (wrEn),
      .wrAddr   (wrAddr),
      .wrData   (wrData),
      .wrStrb   (wrStrb),
      .wrOk     (wrHit),
      .rdAddr   (rdAddr),
      .rdData   (rdWord),
      .rdOk     (rdHit)
   );

   // Every field sits in the low byte, so only lane 0 matters
   assign lowByteWr = wrEn & wrStrb[0];

   always @* begin
      case (wrAddr)
         `OFS_CONTROL,
         `OFS_FAULT_CTL,
         `OFS_FAULT_STAT,
         `OFS_IRQ_MASK,
         `OFS_READBACK,
         `OFS_OFF_LEVEL: wrHit = 1'b1;
         default:        wrHit = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // Fault sources
   // ---------------------------------------------------------------
   assign faultRaw  = {faultCmp1, faultCmp0, faultPin};
   assign faultLive = faultRaw & srcEnable_reg;
   assign anyLive   = |faultLive;

   // No flop between a source and the pins: stopped clock still trips
   assign forceOff  = anyLive | (|shutdown_reg);          // [R7] [R12]

   // Off level per channel, otherwise last registered drive
   assign pwmPinOut = forceOff ? offLevel_reg : pinDrive_reg; // [R1] [R7]

   // Write-one-to-clear strobe for the sticky flags
   assign flagClear = (lowByteWr && wrAddr == `OFS_FAULT_STAT) ?
                      wrData[`FSTAT_FLAG_LSB +: `SRC_COUNT] :
                      {`SRC_COUNT{1'b0}};

   // ---------------------------------------------------------------
   // Per-source latch, flag and restart
   // ---------------------------------------------------------------
   genvar s;
   generate
      for (s = 0; s < `SRC_COUNT; s = s + 1) begin : srcLogic
         always @* begin
            // Set wins over a clear in the same cycle
            faultFlag_next[s] = (faultFlag_reg[s] & ~flagClear[s])
                                | faultLive[s];           // [R15] [R6]
            shutdown_next[s]  = shutdown_reg[s];
            if (faultLive[s]) begin
               shutdown_next[s] = 1'b1;                   // [R1]
            end else if (autoRestart_reg[s]) begin
               // Pulse-by-pulse limit: release on a clean period start
               if (periodStart && !anyLive) begin
                  shutdown_next[s] = 1'b0;                // [R4] [R3]
               end
            end else begin
               // Hard shutdown: held until software acknowledges
               if (!anyLive && !faultFlag_reg[s]) begin
                  shutdown_next[s] = 1'b0;                // [R5] [R3]
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Output drive and pin enables
   // ---------------------------------------------------------------
   always @* begin
      // Halt mode is deliberately not looked at here
      if (modEnable_reg) begin
         pinDrive_next = modRaw;                           // [R8]
      end else begin
         pinDrive_next = offLevel_reg;
      end
   end

   // Stop mode freezes the registered drive as a stopped clock would
   always @(posedge core_clk) begin
      if (sys_rst) begin
         pinDrive_reg <= `RST_OFF_LEVEL;
      end else if (!stopMode) begin
         pinDrive_reg <= pinDrive_next;                    // [R10]
      end
   end

   // A fault while stopped still latches; only the release waits
   always @(posedge core_clk) begin
      if (sys_rst) begin
         shutdown_reg <= {`SRC_COUNT{1'b0}};
      end else if (stopMode) begin
         shutdown_reg <= shutdown_reg | faultLive;         // [R12] [R5]
      end else begin
         shutdown_reg <= shutdown_next;                    // [R2]
      end
   end

   genvar p;
   generate
      for (p = 0; p < `PAIR_COUNT; p = p + 1) begin : pairLogic
         always @(posedge core_clk) begin
            if (sys_rst) begin
               pwmPinOe[2*p +: 2] <= 2'b00;
            end else if (!stopMode) begin
               pwmPinOe[2*p +: 2] <= {2{pairOption_reg[p]}}; // [R14]
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Status, readback and interrupt
   // ---------------------------------------------------------------
   always @(posedge core_clk) begin
      if (sys_rst) begin
         faultFlag_reg <= `RST_FLAGS;
         readback_reg  <= `RST_PINS;
         faultIrq      <= 1'b0;
      end else begin
         faultFlag_reg <= faultFlag_next;                  // [R15]
         readback_reg  <= pwmPinIn;                        // [R13]
         faultIrq      <= |(faultFlag_next & irqMask_reg); // [R6]
      end
   end

   // ---------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------
   always @(posedge core_clk) begin
      if (sys_rst) begin
         modEnable_reg   <= |(`RST_CONTROL & 4'h1);
         pairOption_reg  <= {`PAIR_COUNT{1'b0}};
         srcEnable_reg   <= `RST_SRC_EN;
         autoRestart_reg <= `RST_AUTO;
         irqMask_reg     <= `RST_MASK;
         offLevel_reg    <= `RST_OFF_LEVEL;
      end else if (lowByteWr) begin
         case (wrAddr)
            `OFS_CONTROL: begin
               modEnable_reg  <= wrData[`CTL_ENABLE_BIT];  // [R8]
               pairOption_reg <= wrData[`CTL_PAIR_LSB +: `PAIR_COUNT];
            end
            `OFS_FAULT_CTL: begin
               srcEnable_reg   <= wrData[`FCTL_SRCEN_LSB +: `SRC_COUNT];
               autoRestart_reg <= wrData[`FCTL_AUTO_LSB +: `SRC_COUNT]; // [R2]
            end
            `OFS_IRQ_MASK: begin
               irqMask_reg <= wrData[`SRC_COUNT-1:0];
            end
            `OFS_OFF_LEVEL: begin
               offLevel_reg <= wrData[`CH_COUNT-1:0];
            end
            default: begin
               modEnable_reg <= modEnable_reg;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Read decode
   // ---------------------------------------------------------------
   always @* begin
      rdWord = `DATA_ZERO;
      rdHit  = 1'b1;
      case (rdAddr)
         `OFS_CONTROL: begin
            rdWord[`CTL_ENABLE_BIT] = modEnable_reg;
            rdWord[`CTL_PAIR_LSB +: `PAIR_COUNT] = pairOption_reg;
         end
         `OFS_FAULT_CTL: begin
            rdWord[`FCTL_SRCEN_LSB +: `SRC_COUNT] = srcEnable_reg;
            rdWord[`FCTL_AUTO_LSB +: `SRC_COUNT]  = autoRestart_reg;
         end
         `OFS_FAULT_STAT: begin
            rdWord[`FSTAT_FLAG_LSB +: `SRC_COUNT] = faultFlag_reg; // [R6]
            rdWord[`FSTAT_LIVE_LSB +: `SRC_COUNT] = faultLive;
            rdWord[`FSTAT_OFF_BIT] = forceOff;
         end
         `OFS_IRQ_MASK: begin
            rdWord[`SRC_COUNT-1:0] = irqMask_reg;
         end
         `OFS_READBACK: begin
            rdWord[`CH_COUNT-1:0] = readback_reg;          // [R13]
         end
         `OFS_OFF_LEVEL: begin
            rdWord[`CH_COUNT-1:0] = offLevel_reg;
         end
         default: begin
            rdHit = 1'b0;
         end
      endcase
   end

   // Halt is an input for completeness; running on is the intended effect
   wire haltUnused = haltMode;

endmodule
`default_nettype wire

// ### sim/pwm_fault_output_control_chk.sv
// Assertion checker for the modulator fault and pin control block
`timescale 1ns/1ps
`default_nettype none
module pwm_fault_output_control_chk (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       sys_rst,
   // Register bus
   input wire logic       awready,
   input wire logic       wready,
   input wire logic       bvalid,
   input wire logic       bready,
   input wire logic       arvalid,
   input wire logic       arready,
   input wire logic       rvalid,
   input wire logic       rready,
   // Faults and power modes
   input wire logic       faultPin,
   input wire logic       faultCmp0,
   input wire logic       faultCmp1,
   input wire logic       stopMode,
   // Pins and interrupt
   input wire logic [5:0] pwmPinOut,
   input wire logic [5:0] pwmPinOe,
   input wire logic       faultIrq
);
   logic anyF;

   assign anyF = faultPin | faultCmp0 | faultCmp1;

   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   sequence s_quiet_stop;
      stopMode && !anyF ##1 stopMode && !anyF;
   endsequence
   property p_rst_idle;
      $fell(sys_rst) |-> pwmPinOe == 6'h00 && !faultIrq && !bvalid;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
   property p_pair;
      pwmPinOe[0] == pwmPinOe[1] && pwmPinOe[2] == pwmPinOe[3]
         && pwmPinOe[4] == pwmPinOe[5];
   endproperty
   a_pair: assert property (p_pair) else $error("pair pins split");
   property p_stop_oe;
      stopMode && $past(stopMode) |-> $stable(pwmPinOe);
   endproperty
   a_stop_oe: assert property (p_stop_oe) else $error("enable moved in stop");
   // Stop freezes drive and latches, so only a live fault may move pins
   property p_stop_out;
      s_quiet_stop |-> $stable(pwmPinOut);
   endproperty
   a_stop_out: assert property (p_stop_out) else $error("pins moved in stop");
   property p_irq_rise;
      $rose(faultIrq) |-> $past(anyF) || bvalid || $past(bvalid);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
   property p_irq_fall;
      $fell(faultIrq) && !$past(sys_rst) |-> bvalid || $past(bvalid);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
   property p_bwait;
      $rose(bvalid) |-> !awready && !wready;
   endproperty
   a_bwait: assert property (p_bwait) else $error("ready during response");
   property p_bdone;
      bvalid && bready |=> !bvalid && awready && wready;
   endproperty
   a_bdone: assert property (p_bdone) else $error("write not closed");
   property p_rans;
      arvalid && arready |=> rvalid;
   endproperty
   a_rans: assert property (p_rans) else $error("read not answered");
   property p_rdone;
      rvalid && rready |=> !rvalid && arready;
   endproperty
   a_rdone: assert property (p_rdone) else $error("read not closed");
endmodule

bind pwm_fault_output_control pwm_fault_output_control_chk chkInst (
   .core_clk, .sys_rst, .awready, .wready, .bvalid, .bready, .arvalid,
   .arready, .rvalid, .rready, .faultPin, .faultCmp0, .faultCmp1,
   .stopMode, .pwmPinOut, .pwmPinOe, .faultIrq);
`default_nettype wire

// ### sim/power_stage_model.sv
// Power stage and fault sensing model at the modulator pins
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
   // Pins from the block
   input  wire logic [5:0] pwmPinOut,
   input  wire logic [5:0] pwmPinOe,
   // Bench controls
   input  wire logic [5:0] extLevel,
   input  wire logic [2:0] trip,
   // Back to the block
   output logic      [5:0] pwmPinIn,
   output logic            faultPin,
   output logic            faultCmp0,
   output logic            faultCmp1
);
   // Released pins read the outside level, never the last driven one
   assign pwmPinIn  = (pwmPinOut & pwmPinOe) | (extLevel & ~pwmPinOe);
   // Sense lines are plain levels, with no clock behind them
   assign faultPin  = trip[0];
   assign faultCmp0 = trip[1];
   assign faultCmp1 = trip[2];
endmodule
`default_nettype wire

// ### sim/test_pwm_fault_output_control.sv
// Self-checking bench for the modulator fault and pin control block
`timescale 1ns/1ps
`default_nettype none
`include "pwm_fault_consts.vh"
module test_pwm_fault_output_control;
   logic        core_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, faultIrq;
   logic        periodStart, haltMode, stopMode;
   logic        faultPin, faultCmp0, faultCmp1;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [5:0]  modRaw, pwmPinIn, pwmPinOut, pwmPinOe, extLevel;
   logic [2:0]  trip;
   int          err_total, checks;

   pwm_fault_output_control DUT (.core_clk, .sys_rst, .awvalid, .awready,
      .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
      .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
      .modRaw, .periodStart, .haltMode, .stopMode, .faultPin, .faultCmp0,
      .faultCmp1, .pwmPinIn, .pwmPinOut, .pwmPinOe, .faultIrq);
   power_stage_model PS (.pwmPinOut, .pwmPinOe, .extLevel, .trip,
      .pwmPinIn, .faultPin, .faultCmp0, .faultCmp1);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task chk(input bit ok, input string m);
      checks++;
      if (!ok) begin
         err_total++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
      @(posedge core_clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      // Bounded so a dead slave ends in a mismatch, not a hang
      for (int n = 0; n < 20; n++) begin
         @(posedge core_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      chk(bvalid === 1'b1 && bresp === e, "write response");
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
      @(posedge core_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 20; n++) begin
         @(posedge core_clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      chk(rvalid === 1'b1 && rdata === e && rresp === er, "read data");
   endtask
   task pulse_start;
      periodStart <= 1'b1;
      @(posedge core_clk);
      periodStart <= 1'b0;
      cyc(2);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      chk(pwmPinOe === 6'h00, "pins driven at reset");
      rdc(`OFS_CONTROL, 32'h0, `RESP_OKAY);
      rdc(`OFS_FAULT_CTL, 32'h7, `RESP_OKAY);
      rdc(`OFS_FAULT_STAT, 32'h0, `RESP_OKAY);
      rdc(`OFS_IRQ_MASK, 32'h0, `RESP_OKAY);
      rdc(`OFS_OFF_LEVEL, 32'h0, `RESP_OKAY);
      wr(`OFS_FAULT_STAT, 32'h78, `RESP_OKAY);
      rdc(`OFS_FAULT_STAT, 32'h0, `RESP_OKAY);
      wr(8'h18, 32'hffffffff, `RESP_SLVERR);
      rdc(8'h18, 32'h0, `RESP_SLVERR);
      $display("reset test done");
   endtask
   task t_pins;
      extLevel <= 6'h0c;
      rdc(`OFS_READBACK, 32'h0c, `RESP_OKAY);
      modRaw   <= 6'h2a;
      haltMode <= 1'b1;
      wr(`OFS_CONTROL, 32'hb, `RESP_OKAY);
      cyc(3);
      chk(pwmPinOe === 6'h33, "pair enables");
      chk(pwmPinOut === 6'h2a, "halt output");
      rdc(`OFS_READBACK, 32'h2e, `RESP_OKAY);
      // Modulator stopped after halting, while halt mode is still on
      wr(`OFS_CONTROL, 32'ha, `RESP_OKAY);
      cyc(3);
      chk(pwmPinOut === 6'h00, "disabled output");
      haltMode <= 1'b0;
      modRaw   <= 6'h12;
      wr(`OFS_CONTROL, 32'hf, `RESP_OKAY);
      wr(`OFS_OFF_LEVEL, 32'h2d, `RESP_OKAY);
      wr(`OFS_IRQ_MASK, 32'h7, `RESP_OKAY);
      cyc(3);
      chk(pwmPinOe === 6'h3f && pwmPinOut === 6'h12, "all pairs");
      $display("pin test done");
   endtask
   task t_fault;
      trip <= 3'b001;
      #1;
      chk(pwmPinOut === 6'h2d, "fault not forced");
      cyc(2);
      chk(faultIrq === 1'b1, "no irq");
      rdc(`OFS_FAULT_STAT, 32'h49, `RESP_OKAY);
      trip <= 3'b000;
      cyc(4);
      chk(pwmPinOut === 6'h2d, "early restart");
      rdc(`OFS_FAULT_STAT, 32'h41, `RESP_OKAY);
      wr(`OFS_FAULT_STAT, 32'h1, `RESP_OKAY);
      cyc(3);
      chk(pwmPinOut === 6'h12 && faultIrq === 1'b0, "no restart");
      trip <= 3'b100;
      cyc(2);
      wr(`OFS_FAULT_STAT, 32'h4, `RESP_OKAY);
      rdc(`OFS_FAULT_STAT, 32'h64, `RESP_OKAY);
      trip <= 3'b000;
      wr(`OFS_FAULT_STAT, 32'h4, `RESP_OKAY);
      cyc(3);
      chk(pwmPinOut === 6'h12, "no restart after clear");
      $display("software restart test done");
   endtask
   task t_auto;
      wr(`OFS_FAULT_CTL, 32'h3f, `RESP_OKAY);
      trip <= 3'b010;
      cyc(2);
      trip <= 3'b000;
      cyc(4);
      chk(pwmPinOut === 6'h2d, "restart before period");
      pulse_start;
      chk(pwmPinOut === 6'h12, "no auto restart");
      rdc(`OFS_FAULT_STAT, 32'h02, `RESP_OKAY);
      trip <= 3'b010;
      cyc(1);
      pulse_start;
      chk(pwmPinOut === 6'h2d, "restart with live fault");
      trip <= 3'b000;
      pulse_start;
      chk(pwmPinOut === 6'h12, "cycle limiting");
      wr(`OFS_FAULT_STAT, 32'h2, `RESP_OKAY);
      wr(`OFS_FAULT_CTL, 32'h3e, `RESP_OKAY);
      trip <= 3'b001;
      cyc(3);
      chk(pwmPinOut === 6'h12 && faultIrq === 1'b0, "masked source");
      trip <= 3'b000;
      wr(`OFS_FAULT_CTL, 32'h07, `RESP_OKAY);
      $display("auto restart test done");
   endtask
   task t_stop;
      // Outputs left running into stop to watch them hold
      stopMode <= 1'b1;
      modRaw   <= 6'h3f;
      cyc(3);
      chk(pwmPinOut === 6'h12, "stop hold");
      trip <= 3'b100;
      #1;
      chk(pwmPinOut === 6'h2d, "stop fault");
      cyc(2);
      trip <= 3'b000;
      cyc(3);
      chk(pwmPinOut === 6'h2d, "stop latch");
      stopMode <= 1'b0;
      wr(`OFS_FAULT_STAT, 32'h4, `RESP_OKAY);
      cyc(3);
      chk(pwmPinOut === 6'h3f, "resume after stop");
      wr(`OFS_CONTROL, 32'he, `RESP_OKAY);
      stopMode <= 1'b1;
      cyc(3);
      chk(pwmPinOut === 6'h2d && pwmPinOe === 6'h3f, "parked stop");
      stopMode <= 1'b0;
      $display("stop test done");
   endtask

   task finish_test;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // Clock, reset, sequence and watchdog
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      #200000;
      err_total++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      finish_test;
   end
   initial begin
      {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
      {periodStart, haltMode, stopMode} = 3'h0;
      {awaddr, araddr, wdata} = 48'h0;
      {modRaw, extLevel, trip} = 15'h0;
      wstrb     = 4'hf;
      err_total = 0;
      checks    = 0;
      cyc(5);
      sys_rst <= 1'b0;
      t_reset;
      t_pins;
      t_fault;
      t_auto;
      t_stop;
      finish_test;
   end
endmodule
`default_nettype wire
